/* File: verilog/sfr_consts.svh */
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH
`define SFR_ADDR_STATUS 8'h0D
`define SFR_BIT_THF 7
`define SFR_BIT_TLF 6
`define SFR_BIT_UPD 5
`define SFR_BIT_CNT 4
`define SFR_BIT_ALM 3
`define SFR_BIT_EVT 2
`define SFR_BIT_POR 1
`define SFR_BIT_VLO 0
`define SFR_RESET_VALUE 8'h02
`define SFR_RESET_TEMP_FLAG 1'b0
`define SFR_FLAG_COUNT 8
`define SFR_ALL_KEEP 8'hFF
`define SFR_RDATA_IDLE 8'h00
`endif

/* File: verilog/sfr_pkg.sv */
package sfr_pkg;
  typedef logic [7:0] sfr_byte_t;
endpackage

/* File: verilog/sfr_status_flags.sv */
`timescale 1ns/1ps
`include "sfr_consts.svh"
module sfr_status_flags
  import sfr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic tempValid,
  input wire logic signed [11:0] tempValue,
  input wire logic signed [11:0] high_threshold_value,
  input wire logic signed [11:0] low_threshold_value,
  input wire logic high_flag_reset_bit,
  input wire logic low_flag_reset_bit,
  input wire logic periodicUpdateEvent,
  input wire logic countdownEvent,
  input wire logic alarmMatchEvent,
  input wire logic externalEvent,
  input wire logic voltageLowEvent,
  output logic [7:0] regRdata,
  output logic temp_high_flag,
  output logic temp_low_flag
);
  // ************************************************
  // address decode
  // ************************************************
  // one decode serves both strobes, so read and write never disagree on the map
  function automatic logic sfr_is_status(input logic [7:0] addr);
    sfr_is_status = (addr == `SFR_ADDR_STATUS);
  endfunction

  sfr_byte_t flags;
  wire sfr_byte_t next_flags;
  wire sfr_byte_t setVec;
  wire sfr_byte_t writeKeep;
  wire sfr_byte_t resetKeep;
  wire sfr_byte_t readData;
  wire logic statusHit;
  wire logic writeHit;
  wire logic readHit;
  wire logic aboveHigh;
  wire logic belowLow;

  assign statusHit = sfr_is_status(regAddr);
  assign writeHit = regWrite && sfr_is_status(regAddr);
  assign readHit = regRead && sfr_is_status(regAddr);

  // ************************************************
  // set sources
  // ************************************************
  // strict signed compares, taken only when a fresh measurement is presented
  assign aboveHigh = tempValid && (tempValue > high_threshold_value);
  assign belowLow = tempValid && (tempValue < low_threshold_value);

  assign setVec[`SFR_BIT_THF] = aboveHigh;
  assign setVec[`SFR_BIT_TLF] = belowLow;
  assign setVec[`SFR_BIT_UPD] = periodicUpdateEvent;
  assign setVec[`SFR_BIT_CNT] = countdownEvent;
  assign setVec[`SFR_BIT_ALM] = alarmMatchEvent;
  assign setVec[`SFR_BIT_EVT] = externalEvent;
  // the power-on flag has no hardware source: only reset raises it
  assign setVec[`SFR_BIT_POR] = 1'b0;
  assign setVec[`SFR_BIT_VLO] = voltageLowEvent;

  // ************************************************
  // clear sources
  // ************************************************
  // write data only ever masks: a 1 keeps the bit, a 0 clears it, nothing sets
  assign writeKeep = writeHit ? regWdata : `SFR_ALL_KEEP;
  // the reset bits clear on every cycle they are held, like a write of 0
  assign resetKeep[`SFR_BIT_THF] = ~high_flag_reset_bit;
  assign resetKeep[`SFR_BIT_TLF] = ~low_flag_reset_bit;
  assign resetKeep[`SFR_BIT_UPD] = 1'b1;
  assign resetKeep[`SFR_BIT_CNT] = 1'b1;
  assign resetKeep[`SFR_BIT_ALM] = 1'b1;
  assign resetKeep[`SFR_BIT_EVT] = 1'b1;
  assign resetKeep[`SFR_BIT_POR] = 1'b1;
  assign resetKeep[`SFR_BIT_VLO] = 1'b1;

  // ************************************************
  // per-flag next state
  // ************************************************
  genvar bitIdx;
  generate
    for (bitIdx = 0; bitIdx < `SFR_FLAG_COUNT; bitIdx = bitIdx + 1) begin : g_flag
      // a set in the same cycle as any clear wins, so an event is never lost
      assign next_flags[bitIdx] = (flags[bitIdx] & writeKeep[bitIdx] & resetKeep[bitIdx])
        | setVec[bitIdx];

      a_bit_no_force: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !flags[bitIdx] && !setVec[bitIdx] |=> !flags[bitIdx])
        else $error("flag rose without a hardware event");
      a_bit_zero_clr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        writeHit && !regWdata[bitIdx] && !setVec[bitIdx] |=> !flags[bitIdx])
        else $error("written zero did not clear the flag");
      a_bit_one_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
        writeHit && regWdata[bitIdx] && resetKeep[bitIdx] && !setVec[bitIdx]
        |=> flags[bitIdx] == $past(flags[bitIdx]))
        else $error("written one changed the flag");
      a_bit_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
        setVec[bitIdx] |=> flags[bitIdx])
        else $error("event lost against a clear");
    end
  endgenerate

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flags <= `SFR_RESET_VALUE;
    end else begin
      flags <= next_flags;
    end
  end

  // read data stands one cycle and then falls back to idle, so nothing stale lingers
  assign readData = readHit ? flags : `SFR_RDATA_IDLE;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdata <= `SFR_RDATA_IDLE;
    end else begin
      regRdata <= readData;
    end
  end

  // the mirrors load from the next value so they match the register every cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      temp_high_flag <= `SFR_RESET_TEMP_FLAG;
      temp_low_flag <= `SFR_RESET_TEMP_FLAG;
    end else begin
      temp_high_flag <= next_flags[`SFR_BIT_THF];
      temp_low_flag <= next_flags[`SFR_BIT_TLF];
    end
  end

  // ************************************************
  // checks
  // ************************************************
  a_reset_value: assert property (@(posedge sys_clk) !rst_n |=> flags == `SFR_RESET_VALUE)
    else $error("status reset value wrong");
  a_no_write_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !flags[`SFR_BIT_POR] |=> !flags[`SFR_BIT_POR])
    else $error("power-on flag set by write");
  a_high_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    aboveHigh |=> flags[`SFR_BIT_THF] && temp_high_flag)
    else $error("temp-high flag not set");
  a_low_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    belowLow |=> flags[`SFR_BIT_TLF] && temp_low_flag)
    else $error("temp-low flag not set");
  a_high_reset_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    high_flag_reset_bit && !aboveHigh |=> !flags[`SFR_BIT_THF])
    else $error("high reset bit did not clear");
  a_low_reset_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    low_flag_reset_bit && !belowLow |=> !flags[`SFR_BIT_TLF])
    else $error("low reset bit did not clear");
  a_write_zero_clr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    regWrite && statusHit && !regWdata[`SFR_BIT_POR] |=> !flags[`SFR_BIT_POR])
    else $error("write zero did not clear");
  a_write_one_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    regWrite && statusHit && regWdata[`SFR_BIT_POR] && !high_flag_reset_bit
    |=> flags[`SFR_BIT_POR] == $past(flags[`SFR_BIT_POR]))
    else $error("write one changed flag");
  a_read_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
    regRead && statusHit |=> regRdata == $past(flags))
    else $error("read data mismatch");
  a_read_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !readHit |=> regRdata == `SFR_RDATA_IDLE)
    else $error("read data not idle");
  a_read_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    readHit && !writeHit && !high_flag_reset_bit && !low_flag_reset_bit
    |=> flags == ($past(flags) | $past(setVec)))
    else $error("read changed the flags");
  a_other_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    regWrite && !statusHit && !high_flag_reset_bit && !low_flag_reset_bit
    |=> flags == ($past(flags) | $past(setVec)))
    else $error("write elsewhere changed the flags");
  a_mirror_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    temp_high_flag == flags[`SFR_BIT_THF])
    else $error("temp-high output differs from flag");
  a_mirror_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    temp_low_flag == flags[`SFR_BIT_TLF])
    else $error("temp-low output differs from flag");
  a_high_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    flags[`SFR_BIT_THF] && !high_flag_reset_bit
    && !(writeHit && !regWdata[`SFR_BIT_THF]) |=> flags[`SFR_BIT_THF])
    else $error("temp-high flag dropped without a clear");
  a_low_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    flags[`SFR_BIT_TLF] && !low_flag_reset_bit
    && !(writeHit && !regWdata[`SFR_BIT_TLF]) |=> flags[`SFR_BIT_TLF])
    else $error("temp-low flag dropped without a clear");
  a_both_reset_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    high_flag_reset_bit && low_flag_reset_bit && !aboveHigh && !belowLow
    |=> !temp_high_flag && !temp_low_flag)
    else $error("reset bits did not clear both outputs");
  a_reset_outputs: assert property (@(posedge sys_clk)
    !rst_n |=> !temp_high_flag && !temp_low_flag && regRdata == `SFR_RDATA_IDLE)
    else $error("outputs not at reset value");

  // ************************************************
  // coverage
  // ************************************************
  c_high_event: cover property (@(posedge sys_clk) disable iff (!rst_n) aboveHigh);
  c_set_clear_race: cover property (@(posedge sys_clk) disable iff (!rst_n)
    aboveHigh && regWrite && statusHit && !regWdata[`SFR_BIT_THF]);
  c_low_reset: cover property (@(posedge sys_clk) disable iff (!rst_n)
    flags[`SFR_BIT_TLF] ##1 low_flag_reset_bit);
  c_por_cleared: cover property (@(posedge sys_clk) disable iff (!rst_n)
    writeHit && !regWdata[`SFR_BIT_POR] && flags[`SFR_BIT_POR]);
  c_read_status: cover property (@(posedge sys_clk) disable iff (!rst_n)
    readHit ##1 regRdata != `SFR_RDATA_IDLE);
endmodule

/* File: verif/status_flag_register_bench.sv */
`timescale 1ns/1ps
module status_flag_register_bench;
  import sfr_pkg::*;
  logic sys_clk = 0, rst_n = 0, regWrite = 0, regRead = 0, tempValid = 0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00;
  logic signed [11:0] tempValue = 12'h000, hiThr = 12'h000, loThr = 12'h000;
  logic hiRst = 0, loRst = 0, updEv = 0, cntEv = 0, almEv = 0, extEv = 0, vloEv = 0;
  logic [7:0] regRdata;
  logic temp_high_flag, temp_low_flag;
  sfr_byte_t model, expRd, nxt;
  int miscompares = 0, checked = 0;
  sfr_status_flags sfr_status_flags_i (.sys_clk(sys_clk), .rst_n(rst_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .tempValid(tempValid),
    .tempValue(tempValue), .high_threshold_value(hiThr), .low_threshold_value(loThr),
    .high_flag_reset_bit(hiRst), .low_flag_reset_bit(loRst), .periodicUpdateEvent(updEv),
    .countdownEvent(cntEv), .alarmMatchEvent(almEv), .externalEvent(extEv),
    .voltageLowEvent(vloEv), .regRdata(regRdata), .temp_high_flag(temp_high_flag),
    .temp_low_flag(temp_low_flag));
  initial forever #4 sys_clk = ~sys_clk;
  task check(input string what, input sfr_byte_t seen, input sfr_byte_t exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task reset;
    @(negedge sys_clk);
    rst_n = 0;
    // idle every strobe so nothing from the last test leaks past the release
    {regWrite, regRead, tempValid, hiRst, loRst} = 5'h00;
    {updEv, cntEv, almEv, extEv, vloEv} = 5'h00;
    repeat (6) @(negedge sys_clk);
    rst_n = 1;
    model = 8'h02;
  endtask
  // read cycles stay quiet so the sampled flags are unambiguous
  task cycle;
    @(negedge sys_clk);
    regRead = ($urandom % 4) == 0;
    regAddr = ($urandom % 4 == 0) ? 8'($urandom) : 8'h0D;
    regWrite = !regRead && ($urandom % 3 == 0);
    regWdata = 8'($urandom);
    tempValid = !regRead && ($urandom % 2);
    tempValue = 12'($urandom % 64) - 12'h020;
    hiThr = 12'h008 + 12'($urandom % 8);
    loThr = -hiThr;
    {hiRst, loRst} = regRead ? 2'h0 : 2'($urandom & $urandom & $urandom);
    {updEv, cntEv, almEv, extEv, vloEv} = regRead ? 5'h00 : 5'($urandom & $urandom & $urandom);
    expRd = (regRead && regAddr == 8'h0D) ? model : 8'h00;
    nxt = model;
    if (regWrite && regAddr == 8'h0D) nxt = nxt & regWdata;
    if (hiRst) nxt[7] = 1'b0;
    if (loRst) nxt[6] = 1'b0;
    nxt = nxt | {tempValid && tempValue > hiThr, tempValid && tempValue < loThr,
      updEv, cntEv, almEv, extEv, 1'b0, vloEv};
    @(posedge sys_clk);
    #1;
    check("regRdata", regRdata, expRd);
    check("tempFlags", {6'h00, temp_high_flag, temp_low_flag}, {6'h00, nxt[7:6]});
    model = nxt;
  endtask
  initial begin
    void'($urandom(70));
    for (int t = 0; t < 2; t++) begin
      reset;
      repeat (3000) cycle;
      $display("test %0d done", t);
    end
    tally_and_finish;
  end
  initial begin
    #100000;
    miscompares++;
    tally_and_finish;
  end
endmodule
